// ===== ssa_bit_store.sv
// serial bit store: start address loading, serial access, self-refresh
`timescale 1ns/1ps
`default_nettype none
`include "ssa_map.svh"
module ssa_bit_store
   import ssa_pkg::*;
#(
   parameter int ADDR_W = `SSA_ADDR_W,
   parameter int PAGE_W = `SSA_PAGE_W,
   parameter int REFRESH_CYC = `SSA_REFRESH_CYC,
   parameter int ROW_W = `SSA_ROW_W
)
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic access_clock_n,
   input wire logic address_bit_strobe,
   input wire logic address_bit_input,
   input wire logic address_load_strobe,
   input wire logic write_en_n,
   input wire logic chip_sel_n,
   input wire logic data_in,
   output logic data_out,
   output logic data_out_oe,
   output logic refresh_pulse,
   output logic [ROW_W-1:0] refresh_row
);

   localparam int START_W = ADDR_W - PAGE_W;
   localparam int DEPTH = 1 << ADDR_W;
   localparam int REF_BOUND = REFRESH_CYC;

   function automatic logic rose(input logic now, input logic was);
      return now & ~was;
   endfunction : rose

   // ---------------- core clock domain ----------------
   logic rst_s1_reg;
   logic rst_n_reg;
   logic [`SSA_SYNC_W-1:0] pin_raw;
   logic [`SSA_SYNC_W-1:0] pin_s1_reg;
   logic [`SSA_SYNC_W-1:0] pin_s2_reg;
   logic [`SSA_SYNC_W-1:0] pin_d_reg;
   logic sas_rise;
   logic tas_rise;
   logic [`SSA_START_W-1:0] shift_reg;
   logic [START_W-1:0] start_hold_reg;
   logic load_tgl_reg;

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_s1_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_n_reg <= rst_s1_reg;
      end
   end

   assign pin_raw = {chip_sel_n, address_load_strobe, address_bit_strobe, address_bit_input};

   // two-stage synchronisers for the address pins and select
   genvar gi;
   generate
      for (gi = 0; gi < `SSA_SYNC_W; gi++)
      begin : g_sync
         always_ff @(posedge mclk or negedge rst_n_reg)
         begin
            if (!rst_n_reg)
            begin
               pin_s1_reg[gi] <= 1'b0;
               pin_s2_reg[gi] <= 1'b0;
               pin_d_reg[gi] <= 1'b0;
            end
            else
            begin
               pin_s1_reg[gi] <= pin_raw[gi];
               pin_s2_reg[gi] <= pin_s1_reg[gi];
               pin_d_reg[gi] <= pin_s2_reg[gi];
            end
         end
      end
   endgenerate

   // strobes act on their rising edge while selected
   assign sas_rise = rose(pin_s2_reg[`SSA_PIN_SAS], pin_d_reg[`SSA_PIN_SAS])
                     & ~pin_s2_reg[`SSA_PIN_CS];
   assign tas_rise = rose(pin_s2_reg[`SSA_PIN_TAS], pin_d_reg[`SSA_PIN_TAS])
                     & ~pin_s2_reg[`SSA_PIN_CS];

   always_ff @(posedge mclk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
         shift_reg <= '0;
      else if (sas_rise)
         shift_reg <= {pin_s2_reg[`SSA_PIN_SAD], shift_reg[`SSA_START_W-1:1]};
   end

   // hold start address, signal link by toggle
   always_ff @(posedge mclk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         start_hold_reg <= '0;
         load_tgl_reg <= 1'b0;
      end
      else if (tas_rise)
      begin
         // low start bits only, so a shortened counter keeps A0 at bit 0
         start_hold_reg <= shift_reg[START_W-1:0];
         load_tgl_reg <= ~load_tgl_reg;
      end
   end

   // runs whether or not accesses arrive
   ssa_refresh_timer #(
      .REFRESH_CYC(REFRESH_CYC),
      .ROW_W(ROW_W)
   ) u_refresh (
      .clk(mclk),
      .rst_n(rst_n_reg),
      .refresh_pulse(refresh_pulse),
      .refresh_row(refresh_row)
   );

   // ---------------- access clock domain ----------------
   // trailing (falling) edge performs the access, leading edge commits writes
   logic lrst_s1_reg;
   logic lrst_n_reg;
   logic ltg_s1_reg;
   logic ltg_s2_reg;
   logic seen_reg;
   logic load_pending;
   logic acc_fire;
   logic [ADDR_W-1:0] ptr_reg;
   logic [ADDR_W-1:0] eff_addr;
   logic [ADDR_W-1:0] acc_addr_reg;
   ssa_mode_e mode_reg;
   logic wdata_reg;
   logic oe_on_reg;
   logic oe_off_reg;
   logic mem [0:DEPTH-1];

   always_ff @(negedge access_clock_n or negedge rstn)
   begin
      if (!rstn)
      begin
         lrst_s1_reg <= 1'b0;
         lrst_n_reg <= 1'b0;
      end
      else
      begin
         lrst_s1_reg <= 1'b1;
         lrst_n_reg <= lrst_s1_reg;
      end
   end

   always_ff @(negedge access_clock_n or negedge lrst_n_reg)
   begin
      if (!lrst_n_reg)
      begin
         ltg_s1_reg <= 1'b0;
         ltg_s2_reg <= 1'b0;
      end
      else
      begin
         ltg_s1_reg <= load_tgl_reg;
         ltg_s2_reg <= ltg_s1_reg;
      end
   end

   assign load_pending = ltg_s2_reg ^ seen_reg;
   assign acc_fire = ~chip_sel_n;

   // loaded address sits on a page boundary
   assign eff_addr = load_pending ? {start_hold_reg, {PAGE_W{1'b0}}} : ptr_reg;

   // step by one per access; natural wrap to zero
   always_ff @(negedge access_clock_n or negedge lrst_n_reg)
   begin
      if (!lrst_n_reg)
      begin
         ptr_reg <= '0;
         seen_reg <= 1'b0;
      end
      else if (acc_fire)
      begin
         ptr_reg <= ADDR_W'(eff_addr + 1'b1);
         seen_reg <= ltg_s2_reg;
      end
   end

   // mode chosen by write-select at the trailing edge
   always_ff @(negedge access_clock_n or negedge lrst_n_reg)
   begin
      if (!lrst_n_reg)
      begin
         mode_reg <= SSA_IDLE;
         acc_addr_reg <= '0;
         wdata_reg <= 1'b0;
      end
      else
      begin
         acc_addr_reg <= eff_addr;
         wdata_reg <= data_in;
         if (!acc_fire)
            mode_reg <= SSA_IDLE;
         else if (write_en_n)
            mode_reg <= SSA_READ;
         else
            mode_reg <= SSA_WRITE;
      end
   end

   // one bit out per selected read cycle of the access clock
   always_ff @(negedge access_clock_n or negedge lrst_n_reg)
   begin
      if (!lrst_n_reg)
      begin
         data_out <= 1'b0;
         oe_on_reg <= 1'b0;
      end
      else if (acc_fire && write_en_n)
      begin
         data_out <= mem[eff_addr];
         oe_on_reg <= ~oe_off_reg;
      end
   end

   // output released at the leading edge
   always_ff @(posedge access_clock_n or negedge lrst_n_reg)
   begin
      if (!lrst_n_reg)
         oe_off_reg <= 1'b0;
      else
         oe_off_reg <= oe_on_reg;
   end

   // output on only between trailing and leading edge of a read
   assign data_out_oe = oe_on_reg ^ oe_off_reg;

   // early write and modify-write commit at the leading edge
   always_ff @(posedge access_clock_n)
   begin
      case (mode_reg)
         SSA_WRITE:
            mem[acc_addr_reg] <= wdata_reg;
         SSA_READ:
            if (!write_en_n)
               mem[acc_addr_reg] <= data_in;
         default:
            ;
      endcase
   end

   // ---------------- checks ----------------
   a_shift_lsb: assert property (
      @(posedge mclk) disable iff (!rst_n_reg)
      sas_rise |=> shift_reg == {$past(pin_s2_reg[`SSA_PIN_SAD]),
                                 $past(shift_reg[`SSA_START_W-1:1])})
      else $error("start address bit not shifted in lowest first");

   a_load_page: assert property (
      @(negedge access_clock_n) disable iff (!lrst_n_reg)
      (acc_fire && load_pending) |=> acc_addr_reg[PAGE_W-1:0] == '0)
      else $error("loaded access address not on page boundary");

   a_load_start: assert property (
      @(negedge access_clock_n) disable iff (!lrst_n_reg)
      (acc_fire && load_pending) |=> acc_addr_reg[ADDR_W-1:PAGE_W] == $past(start_hold_reg))
      else $error("access did not start at loaded address");

   a_addr_step: assert property (
      @(negedge access_clock_n) disable iff (!lrst_n_reg)
      (acc_fire ##1 (acc_fire && !load_pending)) |-> eff_addr == ADDR_W'($past(eff_addr) + 1'b1))
      else $error("access address did not advance by one");

   a_addr_span: assert property (
      @(negedge access_clock_n) disable iff (!lrst_n_reg)
      acc_fire |=> acc_addr_reg == $past(eff_addr) && mode_reg != SSA_IDLE)
      else $error("access not placed at the counter address");

   a_addr_wrap: assert property (
      @(negedge access_clock_n) disable iff (!lrst_n_reg)
      (acc_fire && eff_addr == {ADDR_W{1'b1}}) |=> ptr_reg == '0)
      else $error("access counter did not wrap to zero");

   a_read_data: assert property (
      @(negedge access_clock_n) disable iff (!lrst_n_reg)
      (acc_fire && write_en_n) |=> data_out == $past(mem[eff_addr]))
      else $error("read bit does not match stored bit");

   a_write_mode: assert property (
      @(negedge access_clock_n) disable iff (!lrst_n_reg)
      (acc_fire && !write_en_n) |=> mode_reg == SSA_WRITE && wdata_reg == $past(data_in))
      else $error("write select low did not give a write");

   a_hiz_high: assert property (
      @(negedge access_clock_n) disable iff (!lrst_n_reg)
      !data_out_oe)
      else $error("data output driven while access clock high");

   a_refresh_tick: assert property (
      @(posedge mclk) disable iff (!rst_n_reg)
      refresh_pulse |-> ##[1:REF_BOUND] refresh_pulse)
      else $error("self-refresh interval exceeded");

   a_refresh_row: assert property (
      @(posedge mclk) disable iff (!rst_n_reg)
      $rose(refresh_pulse) |-> refresh_row == ROW_W'($past(refresh_row) + 1'b1))
      else $error("refresh row did not advance");

   c_read: cover property (
      @(negedge access_clock_n) disable iff (!lrst_n_reg) acc_fire && write_en_n);
   c_write: cover property (
      @(negedge access_clock_n) disable iff (!lrst_n_reg) acc_fire && !write_en_n);
   c_load: cover property (
      @(negedge access_clock_n) disable iff (!lrst_n_reg) acc_fire && load_pending);
   c_rmw: cover property (
      @(posedge access_clock_n) disable iff (!lrst_n_reg) mode_reg == SSA_READ && !write_en_n);

endmodule : ssa_bit_store
`default_nettype wire

// ===== ssa_bit_store_bench.sv
// self-checking bench for the serial bit store
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got); \
      end \
   end
module ssa_bit_store_bench
   import ssa_pkg::*;
;
   localparam int REF_CYC = 8;
   typedef struct {logic [12:0] start; logic [7:0] bits;} ssa_row_s;
   ssa_row_s rows [4] = '{'{13'h1000, 8'ha5}, '{13'h0001, 8'h3c},
                          '{13'h0ffe, 8'h96}, '{13'h0003, 8'h0f}};
   logic mclk, rstn, access_clock_n, address_bit_strobe, address_bit_input;
   logic address_load_strobe, write_en_n, chip_sel_n, data_in, data_out;
   logic data_out_oe, refresh_pulse, d, on, off;
   logic [12:0] refresh_row, row_seen;
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;

   ssa_bit_store #(.ADDR_W(12), .REFRESH_CYC(REF_CYC)) DUT (.mclk(mclk), .rstn(rstn),
      .access_clock_n(access_clock_n), .address_bit_strobe(address_bit_strobe),
      .address_bit_input(address_bit_input), .address_load_strobe(address_load_strobe),
      .write_en_n(write_en_n), .chip_sel_n(chip_sel_n), .data_in(data_in),
      .data_out(data_out), .data_out_oe(data_out_oe), .refresh_pulse(refresh_pulse),
      .refresh_row(refresh_row));

   ssa_ctl_model ctl (.mclk(mclk), .access_clock_n(access_clock_n),
      .address_bit_strobe(address_bit_strobe), .address_bit_input(address_bit_input),
      .address_load_strobe(address_load_strobe), .write_en_n(write_en_n),
      .chip_sel_n(chip_sel_n), .data_in(data_in), .data_out(data_out),
      .data_out_oe(data_out_oe));

   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         report_and_stop();
      end
   end

   initial
   begin
      rstn = 1'b0;
      fork
         repeat (3) ctl.access(1'b1, 1'b1, 1'b0, 1'b0, d, on, off);
         repeat (6) @(posedge mclk);
      join
      @(posedge mclk);
      rstn <= 1'b1;
      repeat (3) ctl.access(1'b1, 1'b1, 1'b0, 1'b0, d, on, off);
      foreach (rows[r])
      begin
         ctl.load_page(rows[r].start);
         for (int i = 0; i < 8; i++)
         begin
            ctl.access(1'b0, 1'b0, 1'b0, rows[r].bits[i], d, on, off);
            `CHK("write oe", 1'b0, on)
         end
         ctl.load_page(rows[r].start);
         for (int i = 0; i < 8; i++)
         begin
            ctl.access(1'b0, 1'b1, 1'b0, 1'b0, d, on, off);
            `CHK("read bit", rows[r].bits[i], d)
            `CHK("read oe", 1'b1, on)
            `CHK("oe after rise", 1'b0, off)
         end
         $display("row %0d done", r);
      end
      // deselected cycle neither steps nor drives
      ctl.load_page(13'h0001);
      repeat (2) ctl.access(1'b0, 1'b1, 1'b0, 1'b0, d, on, off);
      ctl.access(1'b1, 1'b1, 1'b0, 1'b0, d, on, off);
      `CHK("deselect oe", 1'b0, on)
      ctl.access(1'b0, 1'b1, 1'b0, 1'b0, d, on, off);
      `CHK("after deselect", 1'b1, d)
      $display("deselect done");
      // modify-write of bit 0 on page 2
      ctl.load_page(13'h0002);
      ctl.access(1'b0, 1'b1, 1'b1, 1'b1, d, on, off);
      `CHK("modify read", 1'b0, d)
      ctl.load_page(13'h0002);
      ctl.access(1'b0, 1'b1, 1'b0, 1'b0, d, on, off);
      `CHK("modify stored", 1'b1, d)
      ctl.access(1'b0, 1'b1, 1'b0, 1'b0, d, on, off);
      `CHK("modify next", 1'b1, d)
      $display("modify done");
      // last page written through, then runs over into page 0
      ctl.load_page(13'h0003);
      repeat (1024) ctl.access(1'b0, 1'b0, 1'b0, 1'b0, d, on, off);
      for (int i = 0; i < 8; i++)
      begin
         ctl.access(1'b0, 1'b1, 1'b0, 1'b0, d, on, off);
         `CHK("wrap bit", rows[0].bits[i], d)
      end
      $display("wrap done");
      // refresh runs with the access clock idle
      for (int i = 0; i < REF_CYC + 2 && refresh_pulse !== 1'b1; i++)
      begin
         @(posedge mclk);
         #1;
      end
      row_seen = refresh_row;
      repeat (REF_CYC) @(posedge mclk);
      #1;
      `CHK("refresh pulse", 1'b1, refresh_pulse)
      `CHK("refresh row", row_seen + 13'h0001, refresh_row)
      $display("refresh done");
      @(posedge mclk);
      rstn <= 1'b0;
      #1;
      `CHK("reset oe", 1'b0, data_out_oe)
      `CHK("reset out", 1'b0, data_out)
      `CHK("reset row", 13'h0000, refresh_row)
      $display("reset done");
      report_and_stop();
   end
endmodule : ssa_bit_store_bench
`default_nettype wire

// ===== ssa_ctl_model.sv
// controller model: serial start address and access clock frames
`timescale 1ns/1ps
`default_nettype none
module ssa_ctl_model
(
   input wire logic mclk,
   output logic access_clock_n,
   output logic address_bit_strobe,
   output logic address_bit_input,
   output logic address_load_strobe,
   output logic write_en_n,
   output logic chip_sel_n,
   output logic data_in,
   input wire logic data_out,
   input wire logic data_out_oe
);
   initial
   begin
      access_clock_n = 1'b1;
      address_bit_strobe = 1'b0;
      address_bit_input = 1'b0;
      address_load_strobe = 1'b0;
      write_en_n = 1'b1;
      chip_sel_n = 1'b1;
      data_in = 1'b0;
   end

   task automatic access(input logic sel_n, input logic we_n, input logic rmw,
                         input logic din, output logic dout, output logic oe_on,
                         output logic oe_off);
      chip_sel_n = sel_n;
      write_en_n = we_n;
      data_in = din;
      #8 access_clock_n = 1'b0;
      #1 dout = data_out;
      oe_on = data_out_oe;
      #7 if (rmw) write_en_n = 1'b0;
      #8 access_clock_n = 1'b1;
      #1 oe_off = data_out_oe;
      #7;
   endtask : access

   task automatic load_page(input logic [12:0] start);
      logic d;
      logic a;
      logic b;
      @(posedge mclk);
      chip_sel_n <= 1'b0;
      for (int i = 0; i < 13; i++)
      begin
         @(posedge mclk);
         address_bit_input <= start[i];
         repeat (2) @(posedge mclk);
         address_bit_strobe <= 1'b1;
         repeat (3) @(posedge mclk);
         address_bit_strobe <= 1'b0;
         repeat (2) @(posedge mclk);
      end
      address_load_strobe <= 1'b1;
      repeat (3) @(posedge mclk);
      address_load_strobe <= 1'b0;
      repeat (4) @(posedge mclk);
      repeat (2) access(1'b1, 1'b1, 1'b0, 1'b0, d, a, b);
   endtask : load_page
endmodule : ssa_ctl_model
`default_nettype wire

// ===== ssa_map.svh
// constants for the serial bit store
//
// Summary of operation
// - store 8,388,608 one-bit words; access counter spans every location.
// - one data bit per access clock cycle at an internally generated address.
// - every read or write advances the access address by exactly one.
// - start address selects 1024-word boundaries; low address bits start at zero.
// - own refresh timer and refresh row counter; controller never refreshes.
// - keep data by self-refresh while no access clocks arrive.
// - thirteen start address bits enter serially, lowest first, on address strobe.
// - load strobe copies latched start address into the access counter.
// - write-select high reads, low writes; high-to-low during access gives modify-write.
// - data output off while access clock high, in cycles with select high at the trailing edge, and during early write.
`ifndef SSA_MAP_SVH
`define SSA_MAP_SVH

`define SSA_WORDS 8388608
`define SSA_ADDR_W 23
`define SSA_PAGE_W 10
`define SSA_START_W 13
`define SSA_ROW_W 13
`define SSA_SYNC_W 4
`define SSA_PIN_SAD 0
`define SSA_PIN_SAS 1
`define SSA_PIN_TAS 2
`define SSA_PIN_CS 3
`define SSA_MCLK_NS 20
`define SSA_REFRESH_NS 15600
`define SSA_REFRESH_CYC (`SSA_REFRESH_NS / `SSA_MCLK_NS)

`endif

// ===== ssa_pkg.sv
// types for the serial bit store
package ssa_pkg;

   typedef enum logic [1:0] {
      SSA_IDLE,
      SSA_READ,
      SSA_WRITE
   } ssa_mode_e;

endpackage : ssa_pkg

// ===== ssa_refresh_timer.sv
// self-refresh interval timer and refresh row counter
`timescale 1ns/1ps
`default_nettype none
`include "ssa_map.svh"
module ssa_refresh_timer
#(
   parameter int REFRESH_CYC = `SSA_REFRESH_CYC,
   parameter int ROW_W = `SSA_ROW_W
)
(
   input wire logic clk,
   input wire logic rst_n,
   output logic refresh_pulse,
   output logic [ROW_W-1:0] refresh_row
);

   localparam int CNT_W = $clog2(REFRESH_CYC + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(REFRESH_CYC - 1);

   logic [CNT_W-1:0] cnt_reg;

   // free-running, independent of access activity
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_reg <= '0;
      else if (cnt_reg == LAST)
         cnt_reg <= '0;
      else
         cnt_reg <= cnt_reg + 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         refresh_pulse <= 1'b0;
         refresh_row <= '0;
      end
      else
      begin
         refresh_pulse <= (cnt_reg == LAST);
         if (cnt_reg == LAST)
            refresh_row <= refresh_row + 1'b1;
      end
   end

endmodule : ssa_refresh_timer
`default_nettype wire
